// ### bench/host_cpu_model.sv
/*
  External 8-bit processor on the host data bus and control pins.
  Assumes callers enter its tasks right after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module host_cpu_model (
  // clock
  input wire logic pclk,
  // device side of the data bus
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  // strobes and resolved bus
  output logic [2:0] pins_n,
  output logic [7:0] bus
);
  logic [7:0] drv_data;
  logic drv_on;
  logic [7:0] last;

  // undriven bus shows the inverse of its last level, never a held value
  assign bus = dev_oe ? dev_data : (drv_on ? drv_data : ~last);
  always @(posedge pclk) begin
    last <= bus;
  end

  initial begin
    pins_n = 3'h7;
    drv_data = 8'h00;
    drv_on = 1'b0;
  end

  // data set up 3 cycles, strobe low 4 cycles
  task automatic host_wr(input logic sel_n, input logic [7:0] b);
    drv_data <= b;
    drv_on <= 1'b1;
    repeat (3) @(posedge pclk);
    pins_n <= {sel_n, 2'h1};
    repeat (4) @(posedge pclk);
    pins_n <= 3'h7;
    repeat (3) @(posedge pclk);
    drv_on <= 1'b0;
    @(posedge pclk);
  endtask : host_wr

  // read strobe with select, byte taken before release
  task automatic host_rd(output logic [7:0] b);
    pins_n <= 3'h2;
    repeat (5) @(posedge pclk);
    b = bus;
    pins_n <= 3'h7;
    repeat (5) @(posedge pclk);
  endtask : host_rd
endmodule : host_cpu_model

`default_nettype wire

// ### bench/slave_port_chk.sv
/*
  Checker of APB timing and host read strobes on slave_port_ctrl.
  Assumes one clock and the design's fixed single wait state.
*/
`timescale 1ns/10ps
`default_nettype none

module slave_port_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // host side
  input wire logic [2:0] ctrl_pin_i,
  input wire logic host_data_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////
  // steps of an apb access and a host read
  sequence acc_s; psel && penable && !pready; endsequence
  sequence rd_low_s; !ctrl_pin_i[0] && !ctrl_pin_i[2]; endsequence
  sequence rd_off_s; ctrl_pin_i[0] [*5]; endsequence

  wait_one_a: assert property (acc_s |=> pready)
    else $error("pready late");
  pulse_one_a: assert property (pready |=> !pready)
    else $error("pready held");
  idle_quiet_a: assert property (!psel |-> !pready)
    else $error("pready unasked");
  err_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("bad error answer");
  read_cause_a: assert property ($rose(host_data_oe) |->
    !$past(ctrl_pin_i[0], 2) && !$past(ctrl_pin_i[2], 2))
    else $error("bus driven unasked");
  read_hold_a: assert property (host_data_oe ##0 rd_low_s |=> host_data_oe)
    else $error("bus dropped early");
  read_off_a: assert property (rd_off_s |-> !host_data_oe)
    else $error("bus driven without read");
  desel_off_a: assert property (ctrl_pin_i[2] [*5] |-> !host_data_oe)
    else $error("bus driven deselected");
endmodule : slave_port_chk

bind slave_port_ctrl slave_port_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_pin_i(ctrl_pin_i),
  .host_data_oe(host_data_oe));

`default_nettype wire

// ### bench/slave_port_control_pins_tb_top.sv
/*
  Self-checking bench of slave_port_ctrl with a host processor model.
  Assumes the package constants and one wait state per APB transfer.
*/
`timescale 1ns/10ps
`default_nettype none

module slave_port_control_pins_tb_top;
  import slave_port_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] ctrl_pin_i;
  logic [2:0] ctrl_pin_o;
  logic [2:0] ctrl_pin_oe;
  logic [2:0] pins_n;
  logic [7:0] host_data_i;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic host_buf_ready;
  int bad_count = 0;
  int checks = 0;
  logic [31:0] r;
  logic e;
  logic [7:0] b;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // each control pin shows whoever drives it
  assign ctrl_pin_i = (ctrl_pin_oe & ctrl_pin_o) | (~ctrl_pin_oe & pins_n);

  slave_port_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctrl_pin_i(ctrl_pin_i), .ctrl_pin_o(ctrl_pin_o),
    .ctrl_pin_oe(ctrl_pin_oe), .host_data_i(host_data_i), .host_data_o(host_data_o),
    .host_data_oe(host_data_oe), .host_buf_ready(host_buf_ready));

  host_cpu_model u_host (.pclk(pclk), .dev_data(host_data_o), .dev_oe(host_data_oe),
    .pins_n(pins_n), .bus(host_data_i));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask : chk

  // one transfer; request held until the rising edge that sees pready high
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // answer and read data taken at the completing edge only
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never lands in this time step
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d, r, e);
  endtask : wr

  task automatic rdc(input logic [9:0] ix, input logic [31:0] x);
    apb(1'b0, ix, 8'h00, r, e);
    chk(r, x);
  endtask : rdc

  ////////////////////////////////////////
  task automatic t_reset;
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h7);
    rdc(IDX_ANALOG_SELECT_CFG, 32'h0);
    rdc(IDX_CTRL_PIN_PORT, 32'h0);
    chk({29'h0, ctrl_pin_oe}, 32'h0);
    apb(1'b0, 10'h3FF, 8'h00, r, e);
    chk({r[31:1], e}, 32'h1);
    $display("done reset");
  endtask : t_reset

  task automatic t_gpio;
    wr(IDX_CTRL_PIN_DIR_STATUS, 8'h0A);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h2);
    chk({29'h0, ctrl_pin_oe}, 32'h5);
    wr(IDX_CTRL_PIN_PORT, 8'h00);
    rdc(IDX_CTRL_PIN_PORT, 32'h0);
    chk({26'h0, ctrl_pin_oe, ctrl_pin_o}, 32'h28);
    wr(IDX_ANALOG_SELECT_CFG, {4'h0, PCFG_CTRL_PINS_DIGITAL});
    rdc(IDX_CTRL_PIN_PORT, 32'h2);
    wr(IDX_CTRL_PIN_DIR_STATUS, 8'h07);
    $display("done gpio");
  endtask : t_gpio

  task automatic t_host_wr;
    u_host.host_wr(1'b0, 8'h11);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h7);
    wr(IDX_CTRL_PIN_DIR_STATUS, 8'h17);
    u_host.host_wr(1'b1, 8'h22);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h17);
    u_host.host_wr(1'b0, 8'hAA);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h97);
    u_host.host_wr(1'b0, 8'h55);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'hB7);
    rdc(IDX_HOST_BYTE_LATCH, 32'hAA);
    rdc(IDX_HOST_BYTE_LATCH, 32'h55);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h37);
    wr(IDX_CTRL_PIN_DIR_STATUS, 8'h17);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h17);
    $display("done host write");
  endtask : t_host_wr

  task automatic t_host_rd;
    wr(IDX_HOST_BYTE_LATCH, 8'h3C);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h57);
    u_host.host_rd(b);
    chk({24'h0, b}, 32'h3C);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h17);
    $display("done host read");
  endtask : t_host_rd

  // fill until refused, one extra byte dropped, drain in order
  task automatic t_fifo;
    for (int i = 0; i < HOST_FIFO_DEPTH; i++) u_host.host_wr(1'b0, 8'h40 + 8'(i));
    chk({31'h0, host_buf_ready}, 32'h0);
    u_host.host_wr(1'b0, 8'hEE);
    for (int i = 0; i < HOST_FIFO_DEPTH; i++) rdc(IDX_HOST_BYTE_LATCH, 32'h40 + i);
    rdc(IDX_CTRL_PIN_DIR_STATUS, 32'h37);
    chk({31'h0, host_buf_ready}, 32'h1);
    $display("done buffer");
  endtask : t_fifo

  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gpio();
    t_host_wr();
    t_host_rd();
    t_fifo();
    finish_test();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule : slave_port_control_pins_tb_top

`default_nettype wire

// ### src/byte_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // queue ends
  byte_fifo_if.buf_side q
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic ready;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // ready is a flop so the filling side sees an honest full
  assign push = q.in_valid & st_reg.ready;
  assign pop = q.out_ready & (st_reg.count != '0);
  assign q.in_ready = st_reg.ready;
  assign q.out_valid = (st_reg.count != '0);
  assign q.data_out = mem[st_reg.rptr];

  // pointer and level update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wptr = st_reg.wptr + AW'(1);
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + AW'(1);
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    st_next.ready = (st_next.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wptr] <= q.data_in;
    end
  end

endmodule : byte_fifo

`default_nettype wire

// ### src/byte_fifo_if.sv
/*
  Valid/ready carrier between the port logic and its byte buffer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none

interface byte_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data_in;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] data_out;
  logic out_valid;
  logic out_ready;

  // buffer end
  modport buf_side(input data_in, input in_valid, output in_ready,
                   output data_out, output out_valid, input out_ready);
  // user end
  modport user_side(output data_in, output in_valid, input in_ready,
                    input data_out, input out_valid, output out_ready);
endinterface : byte_fifo_if

`default_nettype wire

// ### src/slave_port_ctrl.sv
/*
  Three-pin control port and its direction/status register, turning the
  data port into a parallel slave port for an external 8-bit processor.
  Assumes an APB master on pclk, asynchronous host pins (synchronised
  here), and software that sets directions and digital mode itself.
*/
// Contract
// - three control pins, each individually input or output outside slave mode
// - enable bit 4 makes pins slave-port controls; 0 means plain I/O
// - a pin selected as analog reads back as zero
// - direction bits drive pin drivers even for analog pins
// - after power-on reset the control pins are analog inputs
// - bit 6 reads 1 until the host reads the processor's byte
// - host write while input unread sets overflow bit 5; software clears
// - bit 3 is unimplemented and reads zero
// - direction 1 is input, 0 output; directions reset 1, others 0
// - read strobe low with select low reads the latch
// - write strobe low with select low writes the latch
// - select is active low; high ignores both strobes
// - transfers start when select and strobe are first seen low together
// - host reaches the byte latch asynchronously to the device clock; here pins and data pass a two-stage pclk sync first
`timescale 1ns/10ps
`default_nettype none

module slave_port_ctrl
  import slave_port_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control pins: bit 0 read strobe, bit 1 write strobe, bit 2 select
  input wire logic [2:0] ctrl_pin_i,
  output logic [2:0] ctrl_pin_o,
  output logic [2:0] ctrl_pin_oe,
  // host data bus
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe,
  // buffer has room for another host byte
  output logic host_buf_ready
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic wr_act;
    logic rd_act;
    logic [2:0] dir;
    logic slave_port_enable;
    logic in_byte_overflow;
    logic out_byte_full;
    logic [7:0] out_latch;
    logic [2:0] port_latch;
    logic [7:0] analog_cfg;
    logic pop_pend;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] pin_o;
    logic [2:0] pin_oe;
    logic [7:0] data_o;
    logic data_oe;
    logic buf_ready;
  } port_state_t;

  port_state_t st_reg;
  port_state_t st_next;

  logic pin0_read_strobe_n;
  logic pin1_write_strobe_n;
  logic pin2_select_n;
  logic wr_low;
  logic rd_low;
  logic wr_start;
  logic rd_end;
  logic in_byte_full;
  logic [2:0] analog_mask;
  logic [9:0] idx;
  logic hit;
  logic access_first;
  logic access_done;
  logic [31:0] rd_mux;
  logic [7:0] status_byte;

  byte_fifo_if #(.WIDTH(BYTE_W)) hq ();

  ////////////////////////////////////////////////////////////////////
  // host byte buffer

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(HOST_FIFO_DEPTH)
  ) u_host_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .q(hq.buf_side)
  );

  // host byte pushed at write start
  assign hq.data_in = st_reg.dat_s2;
  assign hq.in_valid = wr_start;
  // processor read of the latch pops
  assign hq.out_ready = access_done & ~pwrite & st_reg.pop_pend;
  // full while any host byte is waiting
  assign in_byte_full = hq.out_valid;

  ////////////////////////////////////////////////////////////////////
  // pin decode, second sync stage only

  assign pin0_read_strobe_n = st_reg.pin_s2[0];
  assign pin1_write_strobe_n = st_reg.pin_s2[1];
  assign pin2_select_n = st_reg.pin_s2[2];

  assign wr_low = st_reg.slave_port_enable & ~pin2_select_n & ~pin1_write_strobe_n;
  assign rd_low = st_reg.slave_port_enable & ~pin2_select_n & ~pin0_read_strobe_n;
  assign wr_start = wr_low & ~st_reg.wr_act;
  // host read completes when the pair goes inactive
  assign rd_end = st_reg.rd_act & ~rd_low;

  // analog unless the config selects digital control pins
  assign analog_mask =
    (st_reg.analog_cfg[PCFG_LSB +: PCFG_W] == PCFG_CTRL_PINS_DIGITAL) ? 3'h0 : 3'h7;

  ////////////////////////////////////////////////////////////////////
  // apb decode

  assign idx = paddr[11:2];
  assign hit = (idx == IDX_HOST_BYTE_LATCH) || (idx == IDX_CTRL_PIN_PORT) ||
               (idx == IDX_CTRL_PIN_DIR_STATUS) || (idx == IDX_ANALOG_SELECT_CFG);
  // one wait state: pready rises a cycle into the access phase
  assign access_first = psel & penable & ~st_reg.pready;
  assign access_done = psel & penable & st_reg.pready;

  always_comb begin
    status_byte = 8'h00;
    status_byte[BIT_IN_BYTE_FULL] = in_byte_full;
    status_byte[BIT_OUT_BYTE_FULL] = st_reg.out_byte_full;
    status_byte[BIT_IN_BYTE_OVERFLOW] = st_reg.in_byte_overflow;
    status_byte[BIT_SLAVE_PORT_ENABLE] = st_reg.slave_port_enable;
    status_byte[BIT_UNUSED] = 1'b0;
    status_byte[DIR_LSB +: DIR_W] = st_reg.dir;
  end

  // read data selection, upper bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_HOST_BYTE_LATCH: begin
        rd_mux[7:0] = hq.out_valid ? hq.data_out : 8'h00;
      end
      IDX_CTRL_PIN_PORT: begin
        rd_mux[2:0] = st_reg.pin_s2 & ~analog_mask;
      end
      IDX_CTRL_PIN_DIR_STATUS: begin
        rd_mux[7:0] = status_byte;
      end
      IDX_ANALOG_SELECT_CFG: begin
        rd_mux[7:0] = st_reg.analog_cfg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;

    // two-stage sync of asynchronous host pins
    st_next.pin_s1 = ctrl_pin_i;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.dat_s1 = host_data_i;
    st_next.dat_s2 = st_reg.dat_s1;

    st_next.wr_act = wr_low;
    st_next.rd_act = rd_low;

    // completed host read empties the output byte
    if (rd_end) begin
      st_next.out_byte_full = 1'b0;
    end

    // apb answer, held for exactly one cycle
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    if (access_first) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~hit;
      st_next.prdata = rd_mux;
      // pop only the byte that was actually returned
      st_next.pop_pend = (idx == IDX_HOST_BYTE_LATCH) & hq.out_valid;
    end

    // register writes take effect at the completing edge
    if (access_done & pwrite & hit) begin
      case (idx)
        IDX_HOST_BYTE_LATCH: begin
          st_next.out_latch = pwdata[7:0];
          // processor write sets output full, wins over host read
          st_next.out_byte_full = 1'b1;
        end
        IDX_CTRL_PIN_PORT: begin
          st_next.port_latch = pwdata[2:0];
        end
        IDX_CTRL_PIN_DIR_STATUS: begin
          // direction bits, 1 input and 0 output
          st_next.dir = pwdata[DIR_LSB +: DIR_W];
          st_next.slave_port_enable = pwdata[BIT_SLAVE_PORT_ENABLE];
          // software clears overflow by writing zero
          if (!pwdata[BIT_IN_BYTE_OVERFLOW]) begin
            st_next.in_byte_overflow = 1'b0;
          end
        end
        IDX_ANALOG_SELECT_CFG: begin
          st_next.analog_cfg = pwdata[7:0];
        end
        default: begin
          st_next.analog_cfg = st_reg.analog_cfg;
        end
      endcase
    end

    // host write over an unread byte; set beats clear
    if (wr_start & in_byte_full) begin
      st_next.in_byte_overflow = 1'b1;
    end

    // drivers follow direction bits in every mode
    st_next.pin_o = st_reg.port_latch;
    st_next.pin_oe = ~st_reg.dir;

    // drive the latch while a host read is active
    st_next.data_o = st_reg.out_latch;
    st_next.data_oe = rd_low;

    st_next.buf_ready = hq.in_ready;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.dir <= DIR_RST;
      // config reset leaves control pins analog
      st_reg.analog_cfg <= ANALOG_CFG_RST;
      st_reg.port_latch <= PORT_LATCH_RST;
      st_reg.buf_ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign ctrl_pin_o = st_reg.pin_o;
  assign ctrl_pin_oe = st_reg.pin_oe;
  assign host_data_o = st_reg.data_o;
  assign host_data_oe = st_reg.data_oe;
  // registered copy, one cycle behind the buffer's own ready
  assign host_buf_ready = st_reg.buf_ready;

endmodule : slave_port_ctrl

`default_nettype wire

// ### src/slave_port_pkg.sv
/*
  Constants shared by the slave port control block and its byte buffer:
  register indexes, field positions, reset values, buffer shape.
  Assumes an APB master with 32-bit data; byte address = index * 4.
*/
package slave_port_pkg;

  ////////////////////////////////////////////////////////////////////
  // register indexes (byte address is four times the index)
  localparam int unsigned PADDR_W = 12;
  localparam logic [9:0] IDX_HOST_BYTE_LATCH = 10'h008;
  localparam logic [9:0] IDX_CTRL_PIN_PORT = 10'h009;
  localparam logic [9:0] IDX_CTRL_PIN_DIR_STATUS = 10'h089;
  localparam logic [9:0] IDX_ANALOG_SELECT_CFG = 10'h09F;

  ////////////////////////////////////////////////////////////////////
  // field positions of ctrl_pin_dir_status
  localparam int unsigned BIT_IN_BYTE_FULL = 7;
  localparam int unsigned BIT_OUT_BYTE_FULL = 6;
  localparam int unsigned BIT_IN_BYTE_OVERFLOW = 5;
  localparam int unsigned BIT_SLAVE_PORT_ENABLE = 4;
  localparam int unsigned BIT_UNUSED = 3;
  localparam int unsigned DIR_LSB = 0;
  localparam int unsigned DIR_W = 3;

  // analog_select_cfg: low nibble selects analog or digital pins
  localparam int unsigned PCFG_LSB = 0;
  localparam int unsigned PCFG_W = 4;
  localparam logic [3:0] PCFG_CTRL_PINS_DIGITAL = 4'h6;

  ////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [2:0] DIR_RST = 3'h7;
  localparam logic [7:0] ANALOG_CFG_RST = 8'h00;
  localparam logic [2:0] PORT_LATCH_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////
  // host byte buffer
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HOST_FIFO_DEPTH = 16;

endpackage : slave_port_pkg
